// ---- hw/fpio_regs.svh ----
// Purpose: offsets, bit positions and timing constants of the front panel
// Assumes: 16-bit register port at byte offsets
// Notes: definitions only
`ifndef FPIO_REGS_SVH
`define FPIO_REGS_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define FPIO_PULSED_CTRL_OFS 16'h040c
`define FPIO_NIM_STATUS_OFS 16'h0700
`define FPIO_ECL_STATUS_OFS 16'h0706
`define FPIO_LTS_A_OFS 16'h0708
`define FPIO_LTS_B_OFS 16'h070a
`define FPIO_LTS_C_OFS 16'h070c
`define FPIO_TRIG_SEL_OFS 16'h0730
`define FPIO_ECL_DIN_OFS 16'h0732
`define FPIO_ECL_DOUT_OFS 16'h0734
`define FPIO_UCNT0_OFS 16'h07f2
`define FPIO_UCNT1_OFS 16'h07f4
`define FPIO_UCNT2_OFS 16'h07f6
`define FPIO_UCNT3_OFS 16'h07f8
`define FPIO_UCNT4_OFS 16'h07fa
`define FPIO_UCNT5_OFS 16'h07fc
`define FPIO_UCNT6_OFS 16'h07fe
`define FPIO_UCNT7_OFS 16'h0800
`define FPIO_SD_CONFIG_OFS 16'h0848
// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define FPIO_CLR_CNT_BIT 3
`define FPIO_CLK_SEL_BIT 15
`define FPIO_TRIG_SEL_BIT 0
`define FPIO_VETO_BIT 0
`define FPIO_STRB_BIT 1
`define FPIO_SD_CONFIG_RST 16'h0000
`define FPIO_NIM_TRIG 0
`define FPIO_NIM_COPY 1
`define FPIO_NIM_GP 7
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FPIO_CLK_PERIOD_NS 20
`define FPIO_TRIG_PULSE_NS 20
`define FPIO_TRIG_PULSE_CYC \
  ((`FPIO_TRIG_PULSE_NS + `FPIO_CLK_PERIOD_NS - 1) / `FPIO_CLK_PERIOD_NS)
`define FPIO_LED_HOLD_MS 50
`define FPIO_LED_HOLD_CYC (`FPIO_LED_HOLD_MS * 1000000 / `FPIO_CLK_PERIOD_NS)
`define FPIO_CFG_BLINK_MS 100
`define FPIO_CFG_BLINK_CYC \
  (`FPIO_CFG_BLINK_MS * 1000000 / `FPIO_CLK_PERIOD_NS)
`endif

// ---- hw/fpio_pkg.sv ----
// Purpose: shared types of the front panel block
// Assumes: nothing
// Notes: constants live in fpio_regs.svh
package fpio_pkg;
  typedef logic [15:0] fpio_word_t;
  typedef enum logic [1:0] {
    LOCK_IDLE = 2'b01,
    LOCK_BUSY = 2'b10
  } fpio_lock_e;
endpackage : fpio_pkg

// ---- hw/fpio_edge_cnt.sv ----
// Purpose: synchronise one input, find leading edges, count them
// Assumes: clr is a one-cycle pulse
// Notes: an edge in the clear cycle counts as the first one
`timescale 1ns/100ps
module fpio_edge_cnt #(
  parameter int CNT_W = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic din,
  input wire logic clr,
  output logic level,
  output logic rise,
  output logic [CNT_W-1:0] count
);
  logic sync_a;
  logic prev;

  generate
    if (CNT_W < 1) begin : g_bad_width
      $error("fpio_edge_cnt: CNT_W must be at least 1");
    end
  endgenerate

  assign rise = level & ~prev;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sync_a <= 1'b0;
      level <= 1'b0;
      prev <= 1'b0;
    end else if (ce) begin
      sync_a <= din;
      level <= sync_a;
      prev <= level;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      count <= '0;
    end else if (ce) begin
      if (clr) begin
        count <= rise ? CNT_W'(1) : '0;
      end else if (rise) begin
        count <= count + CNT_W'(1);
      end
    end
  end
endmodule : fpio_edge_cnt

// ---- hw/fpio_led_stretch.sv ----
// Purpose: stretch a one-cycle event into a visible indicator flash
// Assumes: HOLD cycles is the visible on-time
// Notes: each new event restarts the on-time
`timescale 1ns/100ps
module fpio_led_stretch #(
  parameter int HOLD = 2500000
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic trig,
  output logic led
);
  localparam int CW = $clog2(HOLD + 1);
  logic [CW-1:0] left;

  generate
    if (HOLD < 1) begin : g_bad_hold
      $error("fpio_led_stretch: HOLD must be at least 1");
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      left <= '0;
      led <= 1'b0;
    end else if (ce) begin
      if (trig) begin
        left <= CW'(HOLD - 1);
        led <= 1'b1;
      end else if (left != '0) begin
        left <= left - CW'(1);
      end else begin
        led <= 1'b0;
      end
    end
  end
endmodule : fpio_led_stretch

// ---- hw/fpio_front_panel.sv ----
// Purpose: front panel NIM/ECL signals, edge counters and status LEDs
// Assumes: mclk is the multiplexed board clock; osc_clk the local oscillator
// Notes: registers are 16 bits wide at their byte offsets
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "fpio_regs.svh"

// How it works
// (RULE1) first diagnostic pair copies board clock
// (RULE2) second diagnostic pair copies NIM input 1
// (RULE3) third diagnostic pair copies local oscillator
// (RULE4) ECL word strobe may be local trigger
// (RULE5) veto level only readable in status
// (RULE6) ECL data bits inputs unless drivers fitted
// (RULE7) bus LED flashes on every access
// (RULE8) config LED blinks while configuring
// (RULE9) status LED 1 flashes on coincidence
// (RULE10) status LED 2 flashes on NIM 1 edge
// (RULE11) status LED 3 flashes on local trigger
// (RULE12) status LED 4 flashes on NIM 7 edge
// (RULE13) every NIM input has an edge counter
// (RULE14) NIM output 0 pulses 20 ns on trigger
// (RULE15) NIM output 1 high during timestamp readout
// (RULE16) NIM output 2 copies link sync flag
// (RULE17) NIM output 3 copies coincidence output
// (RULE18) pulsed bit 3 clears all counters
// (RULE19) link config bit 15 selects clock
// (RULE20) each counter readable at own offset
// (RULE21) inputs synchronised and edge detected first
// (RULE22) LED flashes stretched and retriggered
module fpio_front_panel
  import fpio_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter bit DRIVERS_FITTED = 1'b0,
  parameter int LED_HOLD_CYC = `FPIO_LED_HOLD_CYC,
  parameter int CFG_BLINK_CYC = `FPIO_CFG_BLINK_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output fpio_word_t reg_rdata,
  input wire logic osc_clk,
  input wire logic [7:0] nim_in,
  output logic [3:0] nim_out,
  input wire logic ecl_alt_trigger_input,
  input wire logic ecl_veto_input,
  input wire logic [15:0] ecl_data_in,
  output logic [15:0] ecl_data_out,
  output logic [15:0] ecl_data_oe_b,
  output logic diag_out_muxed_clock_p,
  output logic diag_out_muxed_clock_n,
  output logic diag_out_input_copy_p,
  output logic diag_out_input_copy_n,
  output logic diag_out_oscillator_p,
  output logic diag_out_oscillator_n,
  output logic clk_sel,
  output logic local_trig,
  input wire logic [47:0] latched_ts,
  input wire logic bus_access,
  input wire logic cfg_busy,
  input wire logic coinc_in,
  input wire logic sync_flag,
  output logic led_bus,
  output logic led_cfg,
  output logic led_fw,
  output logic [3:0] led_stat
);
  // ----------------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------------
  generate
    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
      $error("fpio_front_panel: CNT_W must be 1 to 16");
    end
    if (LED_HOLD_CYC < 1 || CFG_BLINK_CYC < 1) begin : g_bad_time
      $error("fpio_front_panel: LED times must be at least one cycle");
    end
  endgenerate

  localparam int PCW = $clog2(`FPIO_TRIG_PULSE_CYC + 1);
  localparam int BCW = $clog2(CFG_BLINK_CYC + 1);
  localparam logic [15:0] UCNT_OFS [8] = '{
    `FPIO_UCNT0_OFS, `FPIO_UCNT1_OFS, `FPIO_UCNT2_OFS, `FPIO_UCNT3_OFS,
    `FPIO_UCNT4_OFS, `FPIO_UCNT5_OFS, `FPIO_UCNT6_OFS, `FPIO_UCNT7_OFS
  };

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [7:0] nim_lvl;
  logic [7:0] nim_rise;
  logic [CNT_W-1:0] cnt [8];
  logic [15:0] cnt_word [8];
  logic [7:0] cnt_hit;
  logic [15:0] cnt_or [9];
  logic [1:0] ecl_sync_a;
  logic [1:0] ecl_lvl;
  logic strb_prev;
  logic strb_rise;
  logic [15:0] ecl_din_a;
  logic [15:0] ecl_din;
  logic [15:0] sd_config;
  logic trig_sel;
  logic [15:0] ecl_dout_reg;
  logic clr_cnt;
  logic trig_rise;
  logic [PCW-1:0] pulse_left;
  fpio_lock_e lock_state;
  fpio_lock_e next_lock_state;
  logic [2:0] ts_seen;
  logic [2:0] next_ts_seen;
  logic [2:0] ts_hit;
  logic coinc_prev;
  logic coinc_rise;
  logic [4:0] led_ev;
  logic [4:0] led_q;
  logic [BCW-1:0] blink_cnt;
  logic blink;
  logic copy_q;
  logic sync_q;
  logic coinc_q;

  // ----------------------------------------------------------------------
  // diagnostic outputs and clock select
  // ----------------------------------------------------------------------
  assign diag_out_muxed_clock_p = mclk; // RULE1
  assign diag_out_muxed_clock_n = ~mclk; // RULE1
  assign diag_out_oscillator_p = osc_clk; // RULE3
  assign diag_out_oscillator_n = ~osc_clk; // RULE3
  assign diag_out_input_copy_p = copy_q; // RULE2
  assign diag_out_input_copy_n = ~copy_q; // RULE2
  assign clk_sel = sd_config[`FPIO_CLK_SEL_BIT]; // RULE19

  // ----------------------------------------------------------------------
  // NIM input synchronisers and edge counters
  // ----------------------------------------------------------------------
  generate
    for (genvar i = 0; i < 8; i++) begin : g_nim
      fpio_edge_cnt #(
        .CNT_W(CNT_W)
      ) u_cnt (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .din(nim_in[i]),
        .clr(clr_cnt),
        .level(nim_lvl[i]),
        .rise(nim_rise[i]),
        .count(cnt[i])
      ); // RULE13 RULE21
      assign cnt_word[i] = 16'(cnt[i]);
      assign cnt_hit[i] = reg_addr == UCNT_OFS[i]; // RULE20
      assign cnt_or[i+1] = cnt_or[i] | ({16{cnt_hit[i]}} & cnt_word[i]);
    end
  endgenerate
  assign cnt_or[0] = 16'h0000;

  // ----------------------------------------------------------------------
  // ECL input synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ecl_sync_a <= 2'h0;
      ecl_lvl <= 2'h0;
      strb_prev <= 1'b0;
      ecl_din_a <= 16'h0000;
      ecl_din <= 16'h0000;
    end else if (ce) begin
      ecl_sync_a <= {ecl_alt_trigger_input, ecl_veto_input}; // RULE21
      ecl_lvl <= ecl_sync_a;
      strb_prev <= ecl_lvl[`FPIO_STRB_BIT];
      ecl_din_a <= ecl_data_in; // RULE6
      ecl_din <= ecl_din_a;
    end
  end
  assign strb_rise = ecl_lvl[`FPIO_STRB_BIT] & ~strb_prev; // RULE21

  // data connector pairs only drive when driver parts are fitted
  assign ecl_data_oe_b = DRIVERS_FITTED ? 16'h0000 : 16'hffff; // RULE6
  assign ecl_data_out = ecl_dout_reg;

  // ----------------------------------------------------------------------
  // register write path
  // ----------------------------------------------------------------------
  wire wr_en = reg_wr & ce;
  wire rd_en = reg_rd & ce;
  wire wr_pulsed = wr_en & (reg_addr == `FPIO_PULSED_CTRL_OFS);
  wire wr_sd = wr_en & (reg_addr == `FPIO_SD_CONFIG_OFS);
  wire wr_tsel = wr_en & (reg_addr == `FPIO_TRIG_SEL_OFS);
  wire wr_dout = wr_en & (reg_addr == `FPIO_ECL_DOUT_OFS);
  // the pulsed register self-clears: nothing is stored
  assign clr_cnt = wr_pulsed & reg_wdata[`FPIO_CLR_CNT_BIT]; // RULE18

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sd_config <= `FPIO_SD_CONFIG_RST;
      trig_sel <= 1'b0;
      ecl_dout_reg <= 16'h0000;
    end else begin
      if (wr_sd) begin
        sd_config <= reg_wdata; // RULE19
      end
      if (wr_tsel) begin
        trig_sel <= reg_wdata[`FPIO_TRIG_SEL_BIT]; // RULE4
      end
      if (wr_dout) begin
        ecl_dout_reg <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // register read path
  // ----------------------------------------------------------------------
  wire hit_nim = reg_addr == `FPIO_NIM_STATUS_OFS;
  wire hit_ecl = reg_addr == `FPIO_ECL_STATUS_OFS;
  wire hit_sd = reg_addr == `FPIO_SD_CONFIG_OFS;
  wire hit_tsel = reg_addr == `FPIO_TRIG_SEL_OFS;
  wire hit_din = reg_addr == `FPIO_ECL_DIN_OFS;
  wire hit_dout = reg_addr == `FPIO_ECL_DOUT_OFS;
  assign ts_hit[0] = reg_addr == `FPIO_LTS_A_OFS;
  assign ts_hit[1] = reg_addr == `FPIO_LTS_B_OFS;
  assign ts_hit[2] = reg_addr == `FPIO_LTS_C_OFS;

  wire [15:0] ecl_status = {14'h0000, ecl_lvl}; // RULE5
  wire [15:0] rd_mux =
      ({16{hit_nim}} & {8'h00, nim_lvl})
    | ({16{hit_ecl}} & ecl_status)
    | ({16{hit_sd}} & sd_config)
    | ({16{hit_tsel}} & {15'h0000, trig_sel})
    | ({16{hit_din}} & ecl_din)
    | ({16{hit_dout}} & ecl_dout_reg)
    | ({16{ts_hit[0]}} & latched_ts[47:32])
    | ({16{ts_hit[1]}} & latched_ts[31:16])
    | ({16{ts_hit[2]}} & latched_ts[15:0])
    | cnt_or[8]; // RULE20

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // local trigger and its output pulse
  // ----------------------------------------------------------------------
  assign trig_rise = trig_sel ? strb_rise : nim_rise[`FPIO_NIM_TRIG]; // RULE4
  assign local_trig = trig_rise;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pulse_left <= '0;
    end else if (ce) begin
      if (trig_rise) begin
        pulse_left <= PCW'(`FPIO_TRIG_PULSE_CYC); // RULE14
      end else if (pulse_left != '0) begin
        pulse_left <= pulse_left - PCW'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // timestamp readout lockout
  // ----------------------------------------------------------------------
  always_comb begin
    next_lock_state = lock_state;
    next_ts_seen = ts_seen;
    case (lock_state)
      LOCK_IDLE: begin
        if (rd_en && ts_hit != 3'h0) begin
          next_lock_state = LOCK_BUSY; // RULE15
          next_ts_seen = ts_hit;
        end
      end
      LOCK_BUSY: begin
        if (rd_en) begin
          next_ts_seen = ts_seen | ts_hit;
        end
        if (next_ts_seen == 3'h7) begin
          next_lock_state = LOCK_IDLE; // RULE15
          next_ts_seen = 3'h0;
        end
      end
      default: begin
        next_lock_state = LOCK_IDLE;
        next_ts_seen = 3'h0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      lock_state <= LOCK_IDLE;
      ts_seen <= 3'h0;
    end else if (ce) begin
      lock_state <= next_lock_state;
      ts_seen <= next_ts_seen;
    end
  end

  // ----------------------------------------------------------------------
  // copied levels and NIM outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      copy_q <= 1'b0;
      sync_q <= 1'b0;
      coinc_q <= 1'b0;
      coinc_prev <= 1'b0;
    end else if (ce) begin
      copy_q <= nim_lvl[`FPIO_NIM_COPY]; // RULE2
      sync_q <= sync_flag; // RULE16
      coinc_q <= coinc_in; // RULE17
      coinc_prev <= coinc_in;
    end
  end
  assign coinc_rise = coinc_in & ~coinc_prev;

  assign nim_out[0] = pulse_left != '0; // RULE14
  assign nim_out[1] = lock_state == LOCK_BUSY; // RULE15
  assign nim_out[2] = sync_q; // RULE16
  assign nim_out[3] = coinc_q; // RULE17

  // ----------------------------------------------------------------------
  // indicators
  // ----------------------------------------------------------------------
  assign led_ev[0] = bus_access | reg_wr | reg_rd; // RULE7
  assign led_ev[1] = coinc_rise; // RULE9
  assign led_ev[2] = nim_rise[`FPIO_NIM_COPY]; // RULE10
  assign led_ev[3] = trig_rise; // RULE11
  assign led_ev[4] = nim_rise[`FPIO_NIM_GP]; // RULE12

  generate
    for (genvar k = 0; k < 5; k++) begin : g_led
      fpio_led_stretch #(
        .HOLD(LED_HOLD_CYC)
      ) u_led (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .trig(led_ev[k]),
        .led(led_q[k])
      ); // RULE22
    end
  endgenerate

  assign led_bus = led_q[0];
  assign led_stat = led_q[4:1];
  assign led_fw = 1'b0; // RULE8

  // configuration blink toggles at a fixed slow rate while busy
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      blink_cnt <= '0;
      blink <= 1'b0;
      led_cfg <= 1'b0;
    end else if (ce) begin
      if (!cfg_busy) begin
        blink_cnt <= '0;
        blink <= 1'b1;
      end else if (blink_cnt == BCW'(CFG_BLINK_CYC - 1)) begin
        blink_cnt <= '0;
        blink <= ~blink;
      end else begin
        blink_cnt <= blink_cnt + BCW'(1);
      end
      led_cfg <= cfg_busy & blink; // RULE8
    end
  end
endmodule : fpio_front_panel

// ---- testbench/fpio_checker_assertions.sv ----
// Purpose: port-level checks of the front panel block
// Assumes: ce held high, LED hold shortened in simulation
// Notes: bound onto the top module at the foot of this file
`timescale 1ns/100ps
`include "fpio_regs.svh"
module fpio_checker #(
  parameter int LED_HOLD_CYC = 4
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic osc_clk,
  input wire logic [7:0] nim_in,
  input wire logic [3:0] nim_out,
  input wire logic diag_out_muxed_clock_p,
  input wire logic diag_out_input_copy_p,
  input wire logic diag_out_oscillator_p,
  input wire logic clk_sel,
  input wire logic local_trig,
  input wire logic coinc_in,
  input wire logic sync_flag,
  input wire logic [3:0] led_stat
);
  // --------------------------------------------------------------------
  // sequences and properties
  // --------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_rd(logic [15:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_ts_set;
    s_rd(`FPIO_LTS_A_OFS) ##2 s_rd(`FPIO_LTS_B_OFS)
      ##2 s_rd(`FPIO_LTS_C_OFS);
  endsequence
  property p_muxed_clk;
    @(negedge mclk) diag_out_muxed_clock_p;
  endproperty
  a_muxed_clk: assert property (p_muxed_clk) else $error("clk copy");
  property p_osc;
    diag_out_oscillator_p == osc_clk;
  endproperty
  a_osc: assert property (p_osc) else $error("osc copy");
  property p_copy;
    $stable(nim_in[1]) [*5] |-> diag_out_input_copy_p == nim_in[1];
  endproperty
  a_copy: assert property (p_copy) else $error("nim1 copy");
  property p_trig;
    nim_out[0] == $past(local_trig);
  endproperty
  a_trig: assert property (p_trig) else $error("trig pulse");
  property p_lock_on;
    reg_rd && (reg_addr inside {`FPIO_LTS_A_OFS, `FPIO_LTS_B_OFS,
      `FPIO_LTS_C_OFS}) && !nim_out[1] |=> nim_out[1];
  endproperty
  a_lock_on: assert property (p_lock_on) else $error("lock on");
  property p_lock_off;
    s_ts_set |=> !nim_out[1];
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("lock off");
  property p_sync;
    nim_out[2] == $past(sync_flag);
  endproperty
  a_sync: assert property (p_sync) else $error("sync copy");
  property p_coinc;
    nim_out[3] == $past(coinc_in);
  endproperty
  a_coinc: assert property (p_coinc) else $error("coinc copy");
  property p_clk_sel;
    reg_wr && reg_addr == `FPIO_SD_CONFIG_OFS
      |=> clk_sel == $past(reg_wdata[`FPIO_CLK_SEL_BIT]);
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clk sel");
  property p_led_coinc;
    $rose(coinc_in) |=> led_stat[0] [*3];
  endproperty
  a_led_coinc: assert property (p_led_coinc) else $error("led");
endmodule : fpio_checker

bind fpio_front_panel fpio_checker #(.LED_HOLD_CYC(LED_HOLD_CYC)) chk_u (.*);

// ---- testbench/fpio_far_side.sv ----
// Purpose: detector electronics driving the NIM inputs and the ECL word strobe
// Assumes: the bench requests a pulse with a one-cycle fire bit
// Notes: bit 8 is the ECL word strobe; pulses sit on the held levels
`timescale 1ns/100ps
module fpio_far_side #(
  parameter int PW = 2
) (
  input wire logic mclk,
  input wire logic [8:0] fire,
  input wire logic [8:0] lvl,
  output logic [7:0] nim_in,
  output logic ecl_alt_trigger_input
);
  int cnt [9];
  logic [8:0] line;
  always @(posedge mclk) begin
    for (int i = 0; i < 9; i++) begin
      if (fire[i]) begin
        cnt[i] <= PW;
      end else if (cnt[i] != 0) begin
        cnt[i] <= cnt[i] - 1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      line[i] = lvl[i] | (cnt[i] != 0);
    end
  end
  assign nim_in = line[7:0];
  assign ecl_alt_trigger_input = line[8];
endmodule : fpio_far_side

// ---- testbench/fpio_front_panel_tb.sv ----
// Purpose: self-checking bench of the front panel block
// Assumes: LED hold and blink counts shortened for simulation
// Notes: random values come from a fixed-seed lfsr
`timescale 1ns/100ps
`include "fpio_regs.svh"
module fpio_front_panel_tb;
  import fpio_pkg::*;
  logic mclk = 1'b0, osc_clk = 1'b0, rst_b = 1'b0, ce = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, ecl_veto_input = 1'b0;
  logic bus_access = 1'b0, cfg_busy = 1'b0;
  logic coinc_in = 1'b0, sync_flag = 1'b0;
  logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, ecl_data_in = 16'h0;
  logic [47:0] latched_ts = 48'h0;
  logic [8:0] fire = 9'h0, lvl = 9'h0;
  fpio_word_t reg_rdata;
  logic [7:0] nim_in;
  logic [3:0] nim_out, led_stat;
  logic [15:0] ecl_data_out, ecl_data_oe_b, d, w;
  logic ecl_alt_trigger_input, clk_sel, local_trig;
  logic diag_out_muxed_clock_p, diag_out_muxed_clock_n;
  logic diag_out_input_copy_p, diag_out_input_copy_n;
  logic diag_out_oscillator_p, diag_out_oscillator_n;
  logic led_bus, led_cfg, led_fw;
  logic [31:0] seed = 32'hf84b;
  logic [2:0] n_edge [8];
  int led_src [3] = '{1, 0, 7};
  int led_pos [3] = '{1, 2, 3};
  int n_fail = 0, num_checks = 0, n_trig = 0, cyc_cnt = 0, t0, hi;
  fpio_front_panel #(.LED_HOLD_CYC(4), .CFG_BLINK_CYC(3)) dut_u (.*);
  fpio_far_side far_u (.mclk, .fire, .lvl, .nim_in, .ecl_alt_trigger_input);
  // --------------------------------------------------------------------
  // clocks, watchdog and helpers
  // --------------------------------------------------------------------
  initial forever #10 mclk = ~mclk;
  initial forever #10.5 osc_clk = ~osc_clk;
  always @(negedge mclk) if (local_trig === 1'b1) n_trig++;
  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [47:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic wr(input logic [15:0] a, v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic pulse(input int i);
    @(posedge mclk);
    fire <= 9'h1 << i;
    @(posedge mclk);
    fire <= 9'h0;
    cyc(4);
    #1;
  endtask : pulse
  task automatic chk_cnts;
    for (int i = 0; i < 8; i++) begin
      rd(`FPIO_UCNT0_OFS + 16'(2 * i), d);
      chk("count", d, n_edge[i]);
    end
  endtask : chk_cnts
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  initial begin
    cyc(2);
    rst_b <= 1'b1;
    rd(`FPIO_SD_CONFIG_OFS, d);
    chk("sd_rst", d, `FPIO_SD_CONFIG_RST);
    for (int j = 0; j < 2; j++) begin
      seed = lfsr(seed);
      w = {~j[0], seed[14:0]};
      wr(`FPIO_SD_CONFIG_OFS, w);
      rd(`FPIO_SD_CONFIG_OFS, d);
      chk("sd_config", d, w);
      chk("clk_sel", clk_sel, w[15]);
    end
    rd(16'h0900, d);
    chk("unmapped", d, 16'h0);
    rd(`FPIO_PULSED_CTRL_OFS, d);
    chk("pulsed", d, 16'h0);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(lfsr(lfsr(seed)));
      n_edge[i] = seed[2:0];
      repeat (n_edge[i]) pulse(i);
    end
    chk_cnts();
    wr(`FPIO_PULSED_CTRL_OFS, 16'h1 << `FPIO_CLR_CNT_BIT);
    n_edge = '{default: 3'h0};
    chk_cnts();
    seed = lfsr(seed);
    lvl <= {1'b0, seed[7:0]};
    ecl_veto_input <= seed[8];
    ecl_data_in <= seed[31:16];
    cyc(5);
    rd(`FPIO_NIM_STATUS_OFS, d);
    chk("nim_lvl", d, {8'h0, lvl[7:0]});
    chk("copy", diag_out_input_copy_p, lvl[1]);
    chk("copy_n", diag_out_input_copy_n, !lvl[1]);
    chk("clk_n", diag_out_muxed_clock_n, !diag_out_muxed_clock_p);
    chk("osc_n", diag_out_oscillator_n, !diag_out_oscillator_p);
    rd(`FPIO_ECL_STATUS_OFS, d);
    chk("veto", d[`FPIO_VETO_BIT], ecl_veto_input);
    rd(`FPIO_ECL_DIN_OFS, d);
    chk("ecl_din", d, ecl_data_in);
    chk("ecl_oe_b", ecl_data_oe_b, 16'hffff);
    wr(`FPIO_ECL_DOUT_OFS, seed[15:0]);
    rd(`FPIO_ECL_DOUT_OFS, d);
    chk("ecl_dout", d, seed[15:0]);
    chk("ecl_dout_pin", ecl_data_out, seed[15:0]);
    lvl <= 9'h0;
    cyc(12);
    for (int i = 0; i < 3; i++) begin
      pulse(led_src[i]);
      chk("led", led_stat[led_pos[i]], 1'b1);
    end
    cyc(12);
    #1 chk("led_off", led_stat, 4'h0);
    t0 = n_trig;
    pulse(0);
    chk("trig_nim", n_trig - t0, 1);
    wr(`FPIO_TRIG_SEL_OFS, 16'h1);
    pulse(8);
    pulse(0);
    chk("trig_ecl", n_trig - t0, 2);
    wr(`FPIO_TRIG_SEL_OFS, 16'h0);
    seed = lfsr(seed);
    latched_ts <= {seed, seed[31:16]};
    for (int i = 0; i < 3; i++) begin
      rd(`FPIO_LTS_A_OFS + 16'(2 * i), d);
      chk("ts", d, latched_ts[47 - 16 * i -: 16]);
      chk("lockout", nim_out[1], i < 2);
    end
    repeat (60) begin
      @(posedge mclk);
      seed = lfsr(seed);
      sync_flag <= seed[0];
      coinc_in <= seed[1] & seed[5];
      bus_access <= seed[2] & seed[7];
      cfg_busy <= seed[9] & seed[10];
    end
    @(posedge mclk);
    coinc_in <= 1'b0;
    bus_access <= 1'b0;
    cfg_busy <= 1'b0;
    cyc(8);
    #1 chk("led_bus_off", led_bus, 1'b0);
    chk("led_cfg_off", led_cfg, 1'b0);
    @(posedge mclk);
    coinc_in <= 1'b1;
    bus_access <= 1'b1;
    @(posedge mclk);
    coinc_in <= 1'b0;
    bus_access <= 1'b0;
    #1 chk("led_coinc", led_stat[0], 1'b1);
    chk("led_bus", led_bus, 1'b1);
    @(posedge mclk);
    cfg_busy <= 1'b1;
    hi = 0;
    repeat (13) begin
      @(negedge mclk);
      hi += int'(led_cfg);
    end
    chk("blink", hi inside {[4:8]}, 1'b1);
    chk("led_fw", led_fw, 1'b0);
    @(posedge mclk);
    cfg_busy <= 1'b0;
    cyc(3);
    finish_test();
  end
endmodule : fpio_front_panel_tb
